// *** pkg/tac_pkg.sv ***
// Shared constants and types of the touch converter command and power control.
// Assumes all users name items as tac_pkg::name, with no import.
package tac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command byte layout.
  localparam int CMD_W = 8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  // Count of bits held when the channel address bit 0 is being sampled.
  localparam logic [3:0] ACQ_BIT = 4'h3;
  // Count of bits held when the last command bit is being sampled.
  localparam logic [3:0] CMD_LAST_BIT = 4'h7;

  // Result lengths for the two resolutions.
  localparam logic [3:0] RES_BITS_HI = 4'hC;
  localparam logic [3:0] RES_BITS_LO = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Power-select codes.
  localparam logic [1:0] PWR_AUTO = 2'h0;
  localparam logic [1:0] PWR_LOW = 2'h1;
  localparam logic [1:0] PWR_RSVD = 2'h2;
  localparam logic [1:0] PWR_ON = 2'h3;

  // Pin synchroniser reset image: serial clock, chip select, data in.
  localparam logic [2:0] PIN_SYNC_RST = 3'h2;

  // Default panel channel addresses for the two position measurements.
  localparam logic [2:0] MEAS_Y_DEF = 3'h1;
  localparam logic [2:0] MEAS_X_DEF = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Field order follows bit 7 down to bit 0 so a byte casts directly.
  typedef struct packed {
    logic start;
    logic chanAddrBit2;
    logic chanAddrBit1;
    logic chanAddrBit0;
    logic res12;
    logic refModeSelect;
    logic powerSelectHi;
    logic powerSelectLo;
  } tac_cmd_s;

  // Panel bias switch controls; a set bit means the switch is closed.
  typedef struct packed {
    logic yPosDrive;
    logic yNegDrive;
    logic xPosDrive;
    logic xNegDrive;
    logic senseXPos;
    logic senseYPos;
  } tac_drive_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_START,
    ST_CONV
  } tac_state_e;

endpackage

// *** design/tac_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to ref_clk; only the second stage is
// meant to be read by other logic.
module tac_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Pins and their synchronised copy
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1_q <= RESET_VAL;
      syncOut <= RESET_VAL;
    end
    else if (clkEn)
    begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end

endmodule

// *** design/tac_shift.sv ***
// Serial-in shift register used to gather the command byte.
// Assumes load and shift are one-cycle strobes on ref_clk; load wins.
module tac_shift #(
  parameter int WIDTH = 8
) (
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Strobes and data
  input wire logic load,
  input wire logic shiftEn,
  input wire logic serialIn,
  output logic [WIDTH-1:0] value
);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      value <= '0;
    else if (clkEn && load)
      value <= {{(WIDTH-1){1'h0}}, serialIn};
    else if (clkEn && shiftEn)
      value <= {value[WIDTH-2:0], serialIn};
  end

endmodule

// *** design/tac_ctrl.sv ***
// Command decode, panel bias sequencing and power sequencing of a four-wire
// resistive touch converter.
// Assumes serial_clk, chip select and data in are pins from the host, while
// the comparator decision comes from converter logic on ref_clk.

module tac_ctrl #(
  parameter logic [2:0] MEAS_Y_ADDR = tac_pkg::MEAS_Y_DEF,
  parameter logic [2:0] MEAS_X_ADDR = tac_pkg::MEAS_X_DEF
) (
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Host serial pins
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOutEn,
  output logic busyOut,
  output logic busyOutEn,
  // Converter core
  input wire logic compDecision,
  output logic sarStep,
  output logic convActive,
  output logic adcPowerOn,
  // Panel and pen interrupt
  output tac_pkg::tac_drive_s panelDrive,
  output logic penTouchIrqEn,
  // Status
  output tac_pkg::tac_cmd_s activeCmd,
  output logic [1:0] appliedPowerSel
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and edge detection.
  logic [2:0] pinSync;
  logic sClkPrev_q;
  logic sClk;
  logic csN;
  logic din;
  logic sRise;
  logic sFall;

  tac_sync #(
    .WIDTH(3),
    .RESET_VAL(tac_pkg::PIN_SYNC_RST)
  ) u_pinSync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .asyncIn({serialClk, chipSelN, serialDataIn}),
    .syncOut(pinSync)
  );

  assign sClk = pinSync[2];
  assign csN = pinSync[1];
  assign din = pinSync[0];
  // Edges are found on the synchronised copy, so they lag the pin by two to
  // three ref_clk cycles; the serial clock must stay well below ref_clk / 4.
  assign sRise = sClk & ~sClkPrev_q;
  assign sFall = ~sClk & sClkPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // State.
  tac_pkg::tac_state_e state_q;
  tac_pkg::tac_state_e state_d;
  logic [3:0] bitCnt_q;
  logic [3:0] bitCnt_d;
  logic [3:0] outCnt_q;
  logic [3:0] outCnt_d;
  tac_pkg::tac_cmd_s cmd_d;
  logic [1:0] applied_d;
  logic [2:0] chan_q;
  logic [2:0] chan_d;
  logic acq_q;
  logic acq_d;
  logic powered_d;
  logic busy_d;
  logic dout_d;
  logic sarStep_d;
  logic conv_d;
  tac_pkg::tac_drive_s drive_d;
  logic penEn_d;

  ////////////////////////////////////////////////////////////////////////////
  // Command byte gathering.
  logic [tac_pkg::CMD_W-1:0] shiftVal;
  logic [tac_pkg::CMD_W-1:0] cmdByte;
  logic startSeen;
  logic cmdShift;
  logic [3:0] resBits;
  logic [1:0] cmdPower;

  assign startSeen = sRise & din & (state_q == tac_pkg::ST_IDLE) & ~csN;
  assign cmdShift = sRise & (state_q == tac_pkg::ST_CMD) & ~csN;
  // The byte is complete in the same cycle its last bit is sampled.
  assign cmdByte = {shiftVal[tac_pkg::CMD_W-2:0], din};

  tac_shift #(
    .WIDTH(tac_pkg::CMD_W)
  ) u_cmdShift (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .load(startSeen),
    .shiftEn(cmdShift),
    .serialIn(din),
    .value(shiftVal)
  );

  assign resBits = activeCmd.res12 ? tac_pkg::RES_BITS_HI :
                   tac_pkg::RES_BITS_LO;
  assign cmdPower = {activeCmd.powerSelectHi, activeCmd.powerSelectLo};

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  always_comb
  begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    outCnt_d = outCnt_q;
    cmd_d = activeCmd;
    applied_d = appliedPowerSel;
    chan_d = chan_q;
    acq_d = acq_q;
    powered_d = adcPowerOn;
    busy_d = busyOut;
    dout_d = serialDataOut;
    sarStep_d = 1'h0;
    conv_d = convActive;
    if (csN)
    begin
      state_d = tac_pkg::ST_IDLE;
      bitCnt_d = tac_pkg::CNT_ZERO;
      outCnt_d = tac_pkg::CNT_ZERO;
      acq_d = 1'h0;
      powered_d = 1'h0;
      busy_d = 1'h0;
      dout_d = 1'h0;
      conv_d = 1'h0;
    end
    else
    begin
      // serial side runs in any power state
      case (state_q)
        tac_pkg::ST_IDLE:
        begin
          if (startSeen)
          begin
            state_d = tac_pkg::ST_CMD;
            bitCnt_d = tac_pkg::CNT_ONE;
          end
        end
        tac_pkg::ST_CMD:
        begin
          if (sRise)
          begin
            bitCnt_d = bitCnt_q + tac_pkg::CNT_ONE;
            if (bitCnt_q == tac_pkg::ACQ_BIT)
            begin
              acq_d = 1'h1;
              chan_d = {shiftVal[1:0], din};
            end
            if (bitCnt_q == tac_pkg::CMD_LAST_BIT)
            begin
              cmd_d = tac_pkg::tac_cmd_s'(cmdByte);
              state_d = tac_pkg::ST_START;
            end
          end
        end
        tac_pkg::ST_START:
        begin
          if (sFall)
          begin
            state_d = tac_pkg::ST_CONV;
            busy_d = 1'h1;
            powered_d = 1'h1;
            conv_d = 1'h1;
            acq_d = 1'h0;
            outCnt_d = tac_pkg::CNT_ZERO;
          end
        end
        tac_pkg::ST_CONV:
        begin
          if (sFall)
          begin
            busy_d = 1'h0;
            if (outCnt_q == resBits)
            begin
              state_d = tac_pkg::ST_IDLE;
              conv_d = 1'h0;
              dout_d = 1'h0;
              applied_d = cmdPower;
              powered_d = (cmdPower == tac_pkg::PWR_ON);
            end
            else
            begin
              dout_d = compDecision;
              sarStep_d = 1'h1;
              outCnt_d = outCnt_q + tac_pkg::CNT_ONE;
            end
          end
        end
        default:
        begin
          state_d = tac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Panel switches, taken from next-state values so they track the pins
  // without an extra cycle of lag.
  logic yMeas;
  logic xMeas;
  logic biasOn;
  logic senseOn;

  assign yMeas = (chan_d == MEAS_Y_ADDR);
  assign xMeas = (chan_d == MEAS_X_ADDR);
  assign biasOn = acq_d | (conv_d & ~cmd_d.refModeSelect);
  assign senseOn = acq_d | conv_d;

  always_comb
  begin
    drive_d.yPosDrive = biasOn & yMeas;
    drive_d.yNegDrive = biasOn & yMeas;
    drive_d.senseXPos = senseOn & yMeas;
    drive_d.xPosDrive = biasOn & xMeas;
    drive_d.xNegDrive = biasOn & xMeas;
    drive_d.senseYPos = senseOn & xMeas;
  end

  // pen interrupt only in code 00
  assign penEn_d = (applied_d == tac_pkg::PWR_AUTO) &
                   (state_d == tac_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sClkPrev_q <= 1'h0;
      state_q <= tac_pkg::ST_IDLE;
      bitCnt_q <= tac_pkg::CNT_ZERO;
      outCnt_q <= tac_pkg::CNT_ZERO;
      chan_q <= 3'h0;
      acq_q <= 1'h0;
    end
    else if (clkEn)
    begin
      sClkPrev_q <= sClk;
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      outCnt_q <= outCnt_d;
      chan_q <= chan_d;
      acq_q <= acq_d;
    end
  end

  // reset to code 00, output zero
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      activeCmd <= '0;
      appliedPowerSel <= tac_pkg::PWR_AUTO;
      adcPowerOn <= 1'h0;
      busyOut <= 1'h0;
      serialDataOut <= 1'h0;
      sarStep <= 1'h0;
      convActive <= 1'h0;
      panelDrive <= '0;
      penTouchIrqEn <= 1'h0;
      serialDataOutEn <= 1'h0;
      busyOutEn <= 1'h0;
    end
    else if (clkEn)
    begin
      activeCmd <= cmd_d;
      appliedPowerSel <= applied_d;
      adcPowerOn <= powered_d;
      busyOut <= busy_d;
      serialDataOut <= dout_d;
      sarStep <= sarStep_d;
      convActive <= conv_d;
      panelDrive <= drive_d;
      penTouchIrqEn <= penEn_d;
      serialDataOutEn <= ~csN;
      busyOutEn <= ~csN;
    end
  end

endmodule

// *** tb/tac_ctrl_asserts.sv ***
// Port checker for tac_ctrl: power, pen, busy and panel bias relations.
// Assumes it is bound onto tac_ctrl and sees the single ref_clk domain.
module tac_ctrl_asserts #(
  parameter logic [2:0] MEAS_Y_ADDR = tac_pkg::MEAS_Y_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Watched outputs
  input wire logic serialDataOut,
  input wire logic busyOut,
  input wire logic busyOutEn,
  input wire logic sarStep,
  input wire logic convActive,
  input wire logic adcPowerOn,
  input wire tac_pkg::tac_drive_s panelDrive,
  input wire logic penTouchIrqEn,
  input wire tac_pkg::tac_cmd_s activeCmd,
  input wire logic [1:0] appliedPowerSel
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  pen_mode_a:
  assert property (appliedPowerSel != 2'h0 |-> !penTouchIrqEn)
    else $error("pen enabled outside auto mode");
  pen_mask_a:
  assert property (convActive |-> !penTouchIrqEn)
    else $error("pen enabled during conversion");
  power_conv_a:
  assert property (convActive |-> adcPowerOn)
    else $error("converter off during conversion");
  busy_start_a:
  assert property ($rose(busyOut) |-> convActive && adcPowerOn)
    else $error("busy without powered conversion");
  // The serial clock may be slowed, so the width bound is loose.
  busy_len_a:
  assert property ($rose(busyOut) |->
    (busyOut || !busyOutEn)[*6] ##[1:8] !busyOut)
    else $error("busy width wrong");
  step_conv_a:
  assert property (sarStep |-> convActive && !busyOut)
    else $error("step outside result phase");
  dout_idle_a:
  assert property (!convActive |-> !serialDataOut)
    else $error("data out high outside conversion");
  busy_off_a:
  assert property (!busyOutEn |-> !busyOut)
    else $error("busy high while released");
  power_down_a:
  assert property ($fell(convActive) && appliedPowerSel != 2'h3
    |-> !adcPowerOn)
    else $error("converter left powered");
  single_open_a:
  assert property (convActive && activeCmd.refModeSelect
    |-> panelDrive[5:2] == 4'h0)
    else $error("drivers closed in single-ended conversion");
  diff_bias_a:
  assert property (convActive && !activeCmd.refModeSelect &&
    activeCmd[6:4] == MEAS_Y_ADDR |-> panelDrive == 6'h32)
    else $error("Y bias lost in differential conversion");
endmodule

bind tac_ctrl tac_ctrl_asserts #(.MEAS_Y_ADDR(MEAS_Y_ADDR))
  tac_ctrl_asserts_inst (.ref_clk, .rst_b, .serialDataOut, .busyOut,
  .busyOutEn, .sarStep, .convActive, .adcPowerOn, .panelDrive,
  .penTouchIrqEn, .activeCmd, .appliedPowerSel);

// *** tb/tac_host.sv ***
// Host serial master model: frames commands and reads results back.
// Assumes ref_clk at 50 MHz; half holds the serial half period in cycles.
module tac_host (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  output logic serialClk,
  output logic chipSelN,
  output logic serialDataIn,
  input wire logic serialDataOut,
  input wire logic busyOut
);
  timeunit 1ns;
  timeprecision 100ps;
  int half = 4;
  initial
  begin
    serialClk = 1'h0;
    chipSelN = 1'h1;
    serialDataIn = 1'h0;
  end
  // short frames of legal codes, clock idles low between them
  task automatic frame(input logic [31:0] pat, input int n, input bit keep,
    output logic [31:0] rx, output logic [31:0] bsy);
    rx = '0;
    bsy = '0;
    chipSelN <= 1'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serialDataIn <= pat[i];
      repeat (half) @(posedge ref_clk);
      serialClk <= 1'h1;
      repeat (half) @(posedge ref_clk);
      // Sampled late in the high phase to cover the pin synchronisers.
      rx = {rx[30:0], serialDataOut};
      bsy = {bsy[30:0], busyOut};
      serialClk <= 1'h0;
    end
    if (!keep)
    begin
      repeat (half) @(posedge ref_clk);
      chipSelN <= 1'h1;
      serialDataIn <= ~serialDataIn;
    end
  endtask
endmodule

// *** tb/tb_tac_ctrl.sv ***
// Self-checking bench for tac_ctrl driven by the host serial model.
// Assumes a 50 MHz ref_clk and a 160 ns serial clock.
module tb_tac_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] cmd;
    logic pwr;
    logic pen;
    logic [1:0] mode;
    logic [5:0] drv;
  } tac_row_s;
  localparam logic [11:0] RES = 12'hB4D;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic clkEn = 1'h1;
  logic serialClk, chipSelN, serialDataIn, compDecision;
  logic serialDataOut, serialDataOutEn, busyOut, busyOutEn;
  logic sarStep, convActive, adcPowerOn, penTouchIrqEn;
  logic [1:0] appliedPowerSel;
  tac_pkg::tac_drive_s panelDrive, preDrv, acqDrv;
  tac_pkg::tac_cmd_s activeCmd;
  logic [31:0] rx, bsy;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int k = 0;
  tac_row_s rows [5] = '{
    '{8'h93, 1'h1, 1'h0, 2'h3, 6'h32},
    '{8'hD8, 1'h0, 1'h1, 2'h0, 6'h0D},
    '{8'hDD, 1'h0, 1'h0, 2'h1, 6'h0D},
    '{8'hA4, 1'h0, 1'h1, 2'h0, 6'h00},
    '{8'h9B, 1'h1, 1'h0, 2'h3, 6'h32}
  };
  tac_ctrl tac_ctrl_inst (.ref_clk, .rst_b, .clkEn, .serialClk,
    .chipSelN, .serialDataIn, .serialDataOut, .serialDataOutEn, .busyOut,
    .busyOutEn, .compDecision, .sarStep, .convActive, .adcPowerOn,
    .panelDrive, .penTouchIrqEn, .activeCmd, .appliedPowerSel);
  // A released output reads as the inverse of its last level at the host.
  tac_host tac_host_inst (.ref_clk, .serialClk, .chipSelN, .serialDataIn,
    .serialDataOut(serialDataOutEn ? serialDataOut : ~serialDataOut),
    .busyOut(busyOutEn ? busyOut : ~busyOut));
  always #10 ref_clk = ~ref_clk;
  assign compDecision = RES[4'hB - k[3:0]];
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    k <= !convActive ? 0 : k + int'(sarStep);
    if (!convActive)
      preDrv <= panelDrive;
    if ($rose(convActive))
      acqDrv <= preDrv;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic run(input logic [31:0] pat, input int n, input bit keep);
    tac_host_inst.frame(pat, n, keep, rx, bsy);
    repeat (8) @(posedge ref_clk);
  endtask
  // Result bits land after the busy clock, three zeros trail a 12-bit result and seven an 8-bit one.
  function automatic logic [31:0] expRx(input logic hi);
    return 32'(hi ? RES : {RES[11:4], 4'h0}) << 3;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'h1;
    // settle time before the first frame
    repeat (500) @(posedge ref_clk);
    foreach (rows[i])
    begin
      run(32'({rows[i].cmd, 16'h0}), 24, 1'h1);
      check(rx, expRx(rows[i].cmd[3]));
      check(bsy, 32'h8000);
      check(acqDrv, 32'(rows[i].drv));
      check(adcPowerOn, 32'(rows[i].pwr));
      check(penTouchIrqEn, 32'(rows[i].pen));
      check(appliedPowerSel, 32'(rows[i].mode));
      check(activeCmd, 32'(rows[i].cmd));
      check({serialDataOutEn, busyOutEn}, 32'h3);
      run(32'h0, 0, 1'h0);
      repeat (500) @(posedge ref_clk);
    end
    tac_host_inst.half = 6;
    run(32'({5'h0, 8'hD8, 16'h0}), 29, 1'h1);
    check(rx, expRx(1'h1));
    check(bsy, 32'h8000);
    tac_host_inst.half = 4;
    run(32'({8'h9B, 16'h0}), 24, 1'h1);
    check(rx, expRx(1'h1));
    // Same address again; only the last command powers down.
    run(32'({8'h98, 16'h0}), 24, 1'h1);
    check(rx, expRx(1'h1));
    check(adcPowerOn, 32'h0);
    // Frozen logic must not notice chip select rising.
    clkEn <= 1'h0;
    run(32'h0, 0, 1'h0);
    check({serialDataOutEn, busyOutEn}, 32'h3);
    clkEn <= 1'h1;
    repeat (8) @(posedge ref_clk);
    check({serialDataOutEn, busyOutEn}, 32'h0);
    // Chip select rises after five result bits of a powered conversion.
    run(32'({8'h9B, 6'h0}), 14, 1'h0);
    check(rx, 32'(RES[11:7]));
    check({convActive, adcPowerOn}, 32'h0);
    check({serialDataOutEn, busyOutEn}, 32'h0);
    run(32'({8'h9B, 16'h0}), 24, 1'h1);
    check(rx, expRx(1'h1));
    check(appliedPowerSel, 32'h3);
    rst_b <= 1'h0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'h1;
    repeat (5) @(posedge ref_clk);
    check({appliedPowerSel, adcPowerOn}, 32'h0);
    check(penTouchIrqEn, 32'h1);
    run(32'({3'h0, 8'hD8, 16'h0}), 27, 1'h0);
    check(rx, expRx(1'h1));
    end_of_test();
  end
endmodule
